// >>> core/drive_start_defines.svh
// Purpose: Constants for the drive start sequencer
// Assumes: 200 MHz clock, 16-bit process data words
// Notes:   Command codes are control word bit patterns
`ifndef DRIVE_START_DEFINES_SVH
`define DRIVE_START_DEFINES_SVH

// ----------------------------------------------------------------
// Process data
// ----------------------------------------------------------------
`define PD_WORDS          6
`define PD_IDX_CONTROL    0
`define PD_IDX_VELOCITY   1
`define PD_IDX_STATUS     0

// ----------------------------------------------------------------
// Control word bits
// ----------------------------------------------------------------
`define CW_SWITCH_ON      0
`define CW_ENABLE_VOLT    1
`define CW_QUICK_STOP_N   2
`define CW_ENABLE_OP      3
`define CW_FAULT_RESET    7

// ----------------------------------------------------------------
// Status word values
// ----------------------------------------------------------------
`define SW_NOT_READY      16'h0000
`define SW_DISABLED       16'h0040
`define SW_READY          16'h0021
`define SW_VOLT_BIT       16'h0010
`define SW_SWITCHED_ON    16'h0023
`define SW_OP_ENABLED     16'h0027
`define SW_QUICK_STOP     16'h0007
`define SW_FAULT          16'h0008
`define SW_REMOTE_BIT     16'h0200
`define SW_RESET          16'h0000

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define CLK_MHZ           200
`define MAINS_TO_MS       1000
`define MAINS_TO_CYCLES   (`MAINS_TO_MS * 1000 * `CLK_MHZ)
`define TIMER_W           32

`endif

// >>> core/drive_start_pkg.sv
// Purpose: Types for the drive start sequencer
// Assumes: No defines are included; the numbers are written here as literals
// Notes:   State codes are binary and fixed
`default_nettype none
package drive_start_pkg;

   typedef enum logic [2:0] {
      ST_NOT_READY  = 3'h0,
      ST_DISABLED   = 3'h1,
      ST_READY      = 3'h2,
      ST_SWITCHED   = 3'h3,
      ST_OP_ENABLED = 3'h4,
      ST_QUICK_STOP = 3'h5,
      ST_FAULT      = 3'h6
   } drive_state_t;

   typedef logic [15:0] pd_word_t;

endpackage
`default_nettype wire

// >>> core/sync2.sv
// Purpose: Two-flop synchroniser for one level
// Assumes: Asynchronous input, single clock
// Notes:   First stage read only by second stage
`default_nettype none
module sync2 (
   input  wire logic clk,
   input  wire logic reset,
   input  wire logic async_in,
   output logic      sync_out
);
   logic meta_q;

   always_ff @(posedge clk) begin
      if (reset) begin
         meta_q   <= 1'b0;
         sync_out <= 1'b0;
      end else begin
         meta_q   <= async_in;
         sync_out <= meta_q;
      end
   end
endmodule // sync2
`default_nettype wire

// >>> core/drive_start_sequencer.sv
// Purpose: Drive-profile start-up state machine with scanner words
// Assumes: Scanner words come from fieldbus logic on clk
// Notes:   Mains supply and fault event are pins
`include "drive_start_defines.svh"
`default_nettype none

module drive_start_sequencer
   import drive_start_pkg::*;
#(
   parameter int unsigned MAINS_TIMEOUT = `MAINS_TO_CYCLES
) (
   input  wire logic     clk,
   input  wire logic     reset,
   input  wire logic     pd_valid,
   input  wire pd_word_t scanner_output_words [`PD_WORDS],
   input  wire logic     mains_present,
   input  wire logic     contactor_mode,
   input  wire logic     fault_event,
   output pd_word_t      scanner_input_words [`PD_WORDS],
   output logic          mains_contactor_close,
   output logic          input_contactor_error,
   output logic          freewheel_stop,
   output logic          motor_run,
   output pd_word_t      velocity_ref
);

   // ----------------------------------------------------------------
   // Pin synchronisers
   // ----------------------------------------------------------------
   logic supply_s;
   logic fault_s;

   sync2 u_sync_supply (
      .clk      (clk),
      .reset    (reset),
      .async_in (mains_present),
      .sync_out (supply_s)
   );

   sync2 u_sync_fault (
      .clk      (clk),
      .reset    (reset),
      .async_in (fault_event),
      .sync_out (fault_s)
   );

   // ----------------------------------------------------------------
   // Command decode
   // ----------------------------------------------------------------
   pd_word_t control_word_out;
   pd_word_t target_velocity_out;
   pd_word_t cw_q;
   logic     fr_prev_q;
   logic     fr_rise;
   logic     cmd_disable;
   logic     cmd_quick;
   logic     cmd_shutdown;
   logic     cmd_switch_on;
   logic     cmd_enable;

   assign control_word_out    = scanner_output_words[`PD_IDX_CONTROL];
   assign target_velocity_out = scanner_output_words[`PD_IDX_VELOCITY];

   // Hold last valid control word between cycles
   always_ff @(posedge clk) begin
      if (reset) begin
         cw_q <= 16'h0000;
      end else if (pd_valid) begin
         cw_q <= control_word_out;
      end
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         fr_prev_q <= 1'b0;
      end else begin
         fr_prev_q <= cw_q[`CW_FAULT_RESET];
      end
   end

   assign fr_rise       = cw_q[`CW_FAULT_RESET] & ~fr_prev_q;
   assign cmd_disable   = ~cw_q[`CW_ENABLE_VOLT];
   assign cmd_quick     = cw_q[`CW_ENABLE_VOLT] & ~cw_q[`CW_QUICK_STOP_N];
   assign cmd_shutdown  = cw_q[`CW_ENABLE_VOLT] & cw_q[`CW_QUICK_STOP_N]
                          & ~cw_q[`CW_SWITCH_ON];
   assign cmd_switch_on = cw_q[`CW_ENABLE_VOLT] & cw_q[`CW_QUICK_STOP_N]
                          & cw_q[`CW_SWITCH_ON] & ~cw_q[`CW_ENABLE_OP];
   assign cmd_enable    = cw_q[`CW_ENABLE_VOLT] & cw_q[`CW_QUICK_STOP_N]
                          & cw_q[`CW_SWITCH_ON] & cw_q[`CW_ENABLE_OP];

   // ----------------------------------------------------------------
   // Mains timeout
   // ----------------------------------------------------------------
   drive_state_t              state_q;
   logic [`TIMER_W-1:0]       mains_cnt_q;
   logic                      timeout_hit;

   assign timeout_hit = (mains_cnt_q >= (`TIMER_W)'(MAINS_TIMEOUT));

   always_ff @(posedge clk) begin
      if (reset) begin
         mains_cnt_q <= '0;
      end else if (state_q == ST_SWITCHED && !supply_s) begin
         if (!timeout_hit) begin
            mains_cnt_q <= mains_cnt_q + 1'b1;
         end
      end else begin
         mains_cnt_q <= '0;
      end
   end

   // ----------------------------------------------------------------
   // Operating state machine
   // ----------------------------------------------------------------
   drive_state_t state_d;

   always_comb begin
      state_d = state_q;
      unique case (state_q)
         ST_NOT_READY: begin
            state_d = ST_DISABLED;
         end
         ST_DISABLED: begin
            if (cmd_shutdown) begin
               state_d = ST_READY;
            end
         end
         ST_READY: begin
            if (cmd_disable || cmd_quick) begin
               state_d = ST_DISABLED;
            end else if (cmd_enable && supply_s) begin
               state_d = ST_OP_ENABLED;
            end else if (cmd_switch_on || cmd_enable) begin
               state_d = ST_SWITCHED;
            end
         end
         ST_SWITCHED: begin
            if (cmd_disable || cmd_quick) begin
               state_d = ST_DISABLED;
            end else if (cmd_shutdown) begin
               state_d = ST_READY;
            end else if (timeout_hit) begin
               state_d = ST_FAULT;
            end else if (cmd_enable && supply_s) begin
               state_d = ST_OP_ENABLED;
            end
         end
         ST_OP_ENABLED: begin
            if (cmd_disable) begin
               state_d = ST_DISABLED;
            end else if (cmd_quick) begin
               state_d = ST_QUICK_STOP;
            end else if (cmd_shutdown) begin
               state_d = ST_READY;
            end else if (cmd_switch_on) begin
               state_d = ST_SWITCHED;
            end
         end
         ST_QUICK_STOP: begin
            if (cmd_disable) begin
               state_d = ST_DISABLED;
            end
         end
         ST_FAULT: begin
            if (fr_rise) begin
               state_d = ST_DISABLED;
            end
         end
         default: begin
            state_d = ST_FAULT;
         end
      endcase
      // External fault wins over any command
      if (fault_s && state_q != ST_NOT_READY) begin
         state_d = ST_FAULT;
      end
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         state_q <= ST_NOT_READY;
      end else begin
         state_q <= state_d;
      end
   end

   // ----------------------------------------------------------------
   // Contactor, error and stop flags
   // ----------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (reset) begin
         mains_contactor_close <= 1'b0;
      end else begin
         // Open again on any return below switched on
         mains_contactor_close <= contactor_mode
            && (state_d == ST_SWITCHED || state_d == ST_OP_ENABLED
                || state_d == ST_QUICK_STOP);
      end
   end

   // Sticky until fault reset; set wins over clear
   always_ff @(posedge clk) begin
      if (reset) begin
         input_contactor_error <= 1'b0;
      end else if (state_q == ST_SWITCHED && state_d == ST_FAULT
                   && timeout_hit) begin
         input_contactor_error <= 1'b1;
      end else if (state_q == ST_FAULT && fr_rise) begin
         input_contactor_error <= 1'b0;
      end
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         freewheel_stop <= 1'b1;
      end else if (state_d == ST_DISABLED) begin
         freewheel_stop <= 1'b1;
      end else if (state_d != ST_NOT_READY) begin
         freewheel_stop <= 1'b0;
      end
   end

   // Zero reference gives no motion
   always_ff @(posedge clk) begin
      if (reset) begin
         motor_run    <= 1'b0;
         velocity_ref <= 16'h0000;
      end else begin
         motor_run    <= (state_d == ST_OP_ENABLED)
                         && (target_velocity_out != 16'h0000);
         velocity_ref <= (state_d == ST_OP_ENABLED) ?
                         target_velocity_out : 16'h0000;
      end
   end

   // ----------------------------------------------------------------
   // Status word
   // ----------------------------------------------------------------
   pd_word_t status_d;

   always_comb begin
      unique case (state_d)
         ST_NOT_READY:  status_d = `SW_NOT_READY;
         ST_DISABLED:   status_d = `SW_DISABLED;
         ST_READY:      status_d = supply_s ?
                           (`SW_READY | `SW_VOLT_BIT) : `SW_READY;
         ST_SWITCHED:   status_d = `SW_SWITCHED_ON | `SW_VOLT_BIT;
         ST_OP_ENABLED: status_d = `SW_OP_ENABLED | `SW_VOLT_BIT;
         ST_QUICK_STOP: status_d = `SW_QUICK_STOP | `SW_VOLT_BIT;
         ST_FAULT:      status_d = `SW_FAULT;
         default:       status_d = `SW_FAULT;
      endcase
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         for (int i = 0; i < `PD_WORDS; i++) begin
            scanner_input_words[i] <= `SW_RESET;
         end
      end else begin
         // Only the status word is defined; others read zero
         for (int i = 0; i < `PD_WORDS; i++) begin
            scanner_input_words[i] <= 16'h0000;
         end
         scanner_input_words[`PD_IDX_STATUS] <= status_d
                                                | `SW_REMOTE_BIT;
      end
   end

endmodule // drive_start_sequencer
`default_nettype wire

// >>> verif/drive_start_chk.sv
// Purpose: Port assertions for the start sequencer
// Assumes: Master refreshes process data every cycle
// Notes:   State read through the 006F status mask
`include "drive_start_defines.svh"
`default_nettype none
module drive_start_chk
   import drive_start_pkg::*;
#(
   parameter int unsigned MAINS_TIMEOUT = 20
) (
   input wire logic     clk,
   input wire logic     reset,
   input wire logic     pd_valid,
   input wire pd_word_t scanner_output_words [`PD_WORDS],
   input wire logic     mains_present,
   input wire logic     contactor_mode,
   input wire logic     fault_event,
   input wire pd_word_t scanner_input_words [`PD_WORDS],
   input wire logic     mains_contactor_close,
   input wire logic     input_contactor_error,
   input wire logic     freewheel_stop,
   input wire logic     motor_run,
   input wire pd_word_t velocity_ref
);
   timeunit 1ns;
   timeprecision 100ps;
   // ------------------------------------------------
   // Properties
   // ------------------------------------------------
   wire pd_word_t st = scanner_input_words[0];
   wire pd_word_t cw = scanner_output_words[0];
   wire pd_word_t sm = st & 16'h006F;
   default clocking cb @(posedge clk); endclocking
   default disable iff (reset);
   // Six cycles covers synchroniser plus status register
   sequence s_supplied; mains_present[*6]; endsequence
   sequence s_absent; (!mains_present)[*6]; endsequence
   sequence s_rst_held; (pd_valid && cw[7])[*4]; endsequence
   property p_volt_on; s_supplied ##0 sm == 16'h0021 |-> st[4]; endproperty
   a_volt_on: assert property (p_volt_on)
      else $error("ready without voltage bit");
   property p_volt_off; s_absent ##0 sm == 16'h0021 |-> !st[4]; endproperty
   a_volt_off: assert property (p_volt_off)
      else $error("voltage bit without supply");
   property p_freewheel; sm == 16'h0040 |-> freewheel_stop; endproperty
   a_freewheel: assert property (p_freewheel)
      else $error("disabled without freewheel flag");
   property p_stop;
      pd_valid && cw == 16'h0000 && !st[3] |-> ##[1:3] sm == 16'h0040;
   endproperty
   a_stop: assert property (p_stop)
      else $error("zero control word did not disable");
   property p_enable;
      (st & 16'h007F) == 16'h0031 && pd_valid && cw == 16'h000F
         && mains_present |-> ##[1:3] sm == 16'h0027;
   endproperty
   a_enable: assert property (p_enable)
      else $error("enable from ready failed");
   property p_contactor;
      contactor_mode && sm == 16'h0021 && pd_valid && cw == 16'h0007
         |-> ##[1:4] mains_contactor_close;
   endproperty
   a_contactor: assert property (p_contactor)
      else $error("contactor not closed");
   property p_err_rise;
      $rose(input_contactor_error) |-> ##[0:2] st[3];
   endproperty
   a_err_rise: assert property (p_err_rise)
      else $error("contactor error without fault");
   property p_err_hold;
      input_contactor_error && !cw[7] && !$past(cw[7])
         |=> input_contactor_error;
   endproperty
   a_err_hold: assert property (p_err_hold)
      else $error("contactor error dropped");
   property p_motor;
      $rose(motor_run) |-> velocity_ref != 16'h0000
         && velocity_ref == $past(scanner_output_words[1]);
   endproperty
   a_motor: assert property (p_motor)
      else $error("motor run without reference");
   property p_rst_edge; s_rst_held ##0 st[3] |=> st[3]; endproperty
   a_rst_edge: assert property (p_rst_edge)
      else $error("fault left without reset edge");
endmodule // drive_start_chk
`default_nettype wire

// >>> verif/fieldbus_master.sv
// Purpose: Cyclic fieldbus master process data model
// Assumes: Bench sets commands on falling edges
// Notes:   Spare words carry a count the drive ignores
`include "drive_start_defines.svh"
`default_nettype none
module fieldbus_master
   import drive_start_pkg::*;
(
   input  wire logic     clk,
   input  wire pd_word_t ctrl_cmd,
   input  wire pd_word_t vel_cmd,
   output logic          pd_valid,
   output pd_word_t      out_words [`PD_WORDS]
);
   timeunit 1ns;
   timeprecision 100ps;
   // ------------------------------------------------
   // Cyclic exchange
   // ------------------------------------------------
   // One process drives every output; reset hides the first cycle
   pd_word_t cnt_q = 16'h0000;
   // Command held each cycle until the bench moves on
   always @(negedge clk) begin
      cnt_q <= cnt_q + 16'h0001;
      pd_valid <= 1'b1;
      out_words[0] <= ctrl_cmd;
      out_words[1] <= vel_cmd;
      for (int i = 2; i < `PD_WORDS; i++) begin
         out_words[i] <= cnt_q;
      end
   end
endmodule // fieldbus_master
`default_nettype wire

// >>> verif/drive_start_sequencer_bench.sv
// Purpose: Self-checking bench for the start sequencer
// Assumes: Mains timeout shortened to 20 cycles
// Notes:   Status waits are bounded at 40 cycles
`include "drive_start_defines.svh"
`default_nettype none
module drive_start_sequencer_bench
   import drive_start_pkg::*;
;
   timeunit 1ns;
   timeprecision 100ps;
   // ------------------------------------------------
   // Stimulus and checks
   // ------------------------------------------------
   logic     clk, reset, mains, cmode, fev, pd_valid;
   logic     close_o, err_o, fw_o, run_o;
   pd_word_t ctrl, vel, vref;
   pd_word_t ow [`PD_WORDS];
   pd_word_t iw [`PD_WORDS];
   int       error_cnt = 0;
   int       tests_run = 0;
   int       cyc_cnt = 0;
   fieldbus_master u_master (.clk, .ctrl_cmd(ctrl), .vel_cmd(vel),
      .pd_valid, .out_words(ow));
   drive_start_sequencer #(.MAINS_TIMEOUT(20)) u_dut (.clk, .reset,
      .pd_valid, .scanner_output_words(ow), .mains_present(mains),
      .contactor_mode(cmode), .fault_event(fev),
      .scanner_input_words(iw), .mains_contactor_close(close_o),
      .input_contactor_error(err_o), .freewheel_stop(fw_o),
      .motor_run(run_o), .velocity_ref(vref));
   task automatic end_sim();
      if (error_cnt == 0 && tests_run > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask
   task automatic chk(input pd_word_t exp, input pd_word_t got);
      tests_run++;
      if (got !== exp) begin
         error_cnt++;
         $display("ERROR t=%0t exp=%h got=%h", $time, exp, got);
      end
   endtask
   task automatic wait_st(input pd_word_t exp);
      for (int i = 0; i < 40 && iw[0] !== exp; i++) @(negedge clk);
      chk(exp, iw[0]);
   endtask
   task automatic cmd(input pd_word_t c);
      @(negedge clk);
      ctrl <= c;
   endtask
   task automatic t_power();
      cmd(16'h0006);
      wait_st(16'h0221);
      mains <= 1'b1;
      wait_st(16'h0231);
      cmd(16'h000F);
      wait_st(16'h0237);
      chk(16'h0000, 16'(fw_o));
      for (int i = 1; i < `PD_WORDS; i++) chk(16'h0000, iw[i]);
      chk(16'h0000, 16'(close_o));
      vel <= 16'h05DC;
      repeat (4) @(negedge clk);
      chk(16'h05DC, vref);
      chk(16'h0001, 16'(run_o));
      vel <= 16'h0000;
      repeat (4) @(negedge clk);
      chk(16'h0000, 16'(run_o));
      vel <= 16'h05DC;
      cmd(16'h0000);
      wait_st(16'h0240);
      chk(16'h0001, 16'(fw_o));
      chk(16'h0000, vref);
   endtask
   task automatic t_contact();
      mains <= 1'b0;
      cmode <= 1'b1;
      cmd(16'h0006);
      wait_st(16'h0221);
      cmd(16'h0007);
      wait_st(16'h0233);
      repeat (2) @(negedge clk);
      chk(16'h0001, 16'(close_o));
      repeat (8) @(negedge clk);
      chk(16'h0233, iw[0]);
      wait_st(16'h0208);
      chk(16'h0001, 16'(err_o));
      cmd(16'h0080);
      wait_st(16'h0240);
      chk(16'h0000, 16'(err_o));
      fev <= 1'b1;
      wait_st(16'h0208);
      fev <= 1'b0;
      repeat (8) @(negedge clk);
      chk(16'h0208, iw[0]);
      cmd(16'h0000);
      cmd(16'h0080);
      wait_st(16'h0240);
   endtask
   // Enable without supply parks in switched on until supply arrives
   task automatic t_separate();
      cmode <= 1'b0;
      cmd(16'h0006);
      wait_st(16'h0221);
      cmd(16'h000F);
      wait_st(16'h0233);
      mains <= 1'b1;
      wait_st(16'h0237);
      chk(16'h0000, 16'(err_o));
      cmd(16'h0002);
      wait_st(16'h0217);
      cmd(16'h0000);
      wait_st(16'h0240);
      chk(16'h0001, 16'(fw_o));
   endtask
   initial begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end
   // Hang guard well above the expected run length
   always @(posedge clk) begin
      cyc_cnt <= cyc_cnt + 1;
      if (cyc_cnt == 3000) begin
         error_cnt++;
         end_sim();
      end
   end
   initial begin
      reset = 1'b1;
      mains = 1'b0;
      cmode = 1'b0;
      fev = 1'b0;
      ctrl = 16'h0000;
      vel = 16'h0000;
      repeat (16) @(negedge clk);
      reset <= 1'b0;
      wait_st(16'h0240);
      t_power();
      t_contact();
      t_separate();
      end_sim();
   end
endmodule // drive_start_sequencer_bench
bind drive_start_sequencer drive_start_chk #(.MAINS_TIMEOUT(MAINS_TIMEOUT))
   u_chk (.clk, .reset, .pd_valid, .scanner_output_words, .mains_present,
   .contactor_mode, .fault_event, .scanner_input_words,
   .mains_contactor_close, .input_contactor_error, .freewheel_stop,
   .motor_run, .velocity_ref);
`default_nettype wire
